// ===== tcp_pkg.sv
// Package with register map, field layouts and mode encodings of the compare/PWM timer.
// Operation
// RULE1 - Unlocked compare writes apply at cycle end
// RULE2 - Locked compare writes stay buffered, inactive
// RULE3 - Lock release loads whole set at cycle end
// RULE4 - Enable and slope pick mode; output bits don't
// RULE5 - Normal mode counts BOTTOM to TOP, restarts
// RULE6 - Normal match toggles, clears or sets output
// RULE7 - Counter clears the cycle after TOP
// RULE8 - Normal overflow flag sets as counter zeroes
// RULE9 - Software may write counter any time
// RULE10 - Normal pins: 00 none, else true pin
// RULE11 - Fast PWM counts single slope to TOP
// RULE12 - Fast PWM clears/sets on match and BOTTOM
// RULE13 - Codes two, three, one: non-inv, inv, pair
// RULE14 - Fast PWM overflow flag sets at TOP
// RULE15 - TOP extremes give spike or constant level
// RULE16 - Fast PWM pins: 00 none, 01 both, else one
// RULE17 - Override needs nonzero mode and output direction
// RULE18 - Output mode change acts at next match
// RULE19 - Reset forces compare output state to zero
// RULE20 - Shadow storage keeps active compare values stable
package tcp_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_CMP_A   = 12'h004;
    localparam logic [11:0] ADDR_CMP_B   = 12'h008;
    localparam logic [11:0] ADDR_CMP_D   = 12'h00c;
    localparam logic [11:0] ADDR_TOP     = 12'h010;
    localparam logic [11:0] ADDR_COUNT   = 12'h014;
    localparam logic [11:0] ADDR_STATUS  = 12'h018;
    localparam logic [11:0] ADDR_PORT    = 12'h01c;

    // ------------------------------------------------------------------
    // Control, status and port register fields
    // ------------------------------------------------------------------
    localparam int CTRL_PWM_EN  = 0;
    localparam int CTRL_SLOPE   = 1;
    localparam int CTRL_LOCK    = 2;
    localparam int CTRL_COM_LSB = 4;   // Two bits per channel from here.
    localparam int STAT_OVF     = 0;
    localparam int PORT_DIR_LSB = 8;   // Port values in low bits, directions above.

    localparam int CNT_W  = 10;
    localparam int NCH    = 3;
    localparam logic [9:0] TOP_RESET = 10'h3ff;
    localparam logic [9:0] BOTTOM    = 10'h000;

    // Compare output mode codes.
    typedef enum logic [1:0] {
        TCP_COM_OFF  = 2'h0,
        TCP_COM_TGL  = 2'h1,
        TCP_COM_CLR  = 2'h2,
        TCP_COM_SET  = 2'h3
    } tcp_com_t;

endpackage

// ===== tcp_wave.sv
// One waveform channel: match action, output state and pin routing.
`timescale 1ns/1ns
module tcp_wave (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // Mode and events
    input  wire logic        pwm_mode_enable,
    input  wire logic [1:0]  compare_output_mode,
    input  wire logic        match,
    input  wire logic        at_bottom,
    // Port fallback
    input  wire logic        port_true,
    input  wire logic        port_comp,
    input  wire logic        dir_true,
    input  wire logic        dir_comp,
    // Pins
    output logic             pin_true_o,
    output logic             pin_comp_o,
    output logic             pin_true_oe,
    output logic             pin_comp_oe
);
    logic waveform_output_q;
    logic waveform_output_d;
    logic compare_pin_q;
    logic [1:0] com;
    logic inverting;
    logic true_conn;
    logic comp_conn;

    // Mode bits are sampled live: the waveform takes a change at the next match (in fast PWM also at BOTTOM), the pin routing at once.
    assign com       = compare_output_mode;                                      // RULE18
    assign inverting = (com == tcp_pkg::TCP_COM_SET);

    // Waveform next state; a match on the same cycle as BOTTOM wins so compare=TOP gives a constant level.
    always_comb begin
        waveform_output_d = waveform_output_q;
        if (!pwm_mode_enable) begin
            if (match) begin
                unique case (com)
                    tcp_pkg::TCP_COM_TGL: waveform_output_d = ~waveform_output_q;  // RULE6
                    tcp_pkg::TCP_COM_CLR: waveform_output_d = 1'b0;                // RULE6
                    tcp_pkg::TCP_COM_SET: waveform_output_d = 1'b1;                // RULE6
                    default:              waveform_output_d = waveform_output_q;
                endcase
            end
        end else if (com != tcp_pkg::TCP_COM_OFF) begin
            if (at_bottom) begin
                waveform_output_d = ~inverting;                                  // RULE12 RULE13
            end
            if (match) begin
                waveform_output_d = inverting;                                   // RULE12 RULE15
            end
        end
    end

    // Pin connection per mode code.
    assign true_conn = (com != tcp_pkg::TCP_COM_OFF);                            // RULE10 RULE16
    assign comp_conn = pwm_mode_enable && (com == tcp_pkg::TCP_COM_TGL);         // RULE16 RULE13

    // Output stage delays the waveform two timer cycles, cleared by reset.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            waveform_output_q <= 1'b0;
            compare_pin_q     <= 1'b0;                                           // RULE19
            pin_true_o        <= 1'b0;
            pin_comp_o        <= 1'b0;
            pin_true_oe       <= 1'b0;
            pin_comp_oe       <= 1'b0;
        end else begin
            waveform_output_q <= waveform_output_d;
            compare_pin_q     <= waveform_output_q;
            pin_true_o        <= true_conn ? compare_pin_q : port_true;          // RULE17
            pin_comp_o        <= comp_conn ? ~compare_pin_q : port_comp;         // RULE17
            pin_true_oe       <= dir_true;                                       // RULE17
            pin_comp_oe       <= dir_comp;
        end
    end
endmodule

// ===== tcp_count.sv
// Single-slope counter from BOTTOM to TOP with overflow event.
`timescale 1ns/1ns
module tcp_count #(
    parameter int W = 10
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          arst_n,
    // Configuration
    input  wire logic [W-1:0]  top_value,
    input  wire logic          load,
    input  wire logic [W-1:0]  load_value,
    // State
    output logic [W-1:0]       counter_value,
    output logic               at_top,
    output logic               wrap
);
    logic [W-1:0] cnt_q;

    assign counter_value = cnt_q;
    assign at_top = (cnt_q == top_value);
    assign wrap   = at_top && !load;

    // Count up, clear the cycle after TOP; software load wins at any time.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_value;                                                 // RULE9
        end else if (at_top) begin
            cnt_q <= '0;                                                         // RULE7 RULE5 RULE11
        end else begin
            cnt_q <= W'(cnt_q + 1'b1);                                           // RULE5 RULE11
        end
    end
endmodule

// ===== tcp_top.sv
// Top of the compare/PWM timer: APB registers, compare shadowing and channel wiring.
`timescale 1ns/1ns
module tcp_top #(
    parameter int W = 10
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          arst_n,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Compare pins, three channels
    output logic [2:0]         pin_true_o,
    output logic [2:0]         pin_true_oe,
    output logic [2:0]         pin_comp_o,
    output logic [2:0]         pin_comp_oe
);
    localparam int NCH = tcp_pkg::NCH;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]         ctrl_q;
    logic [7:0]         ctrl_hi_q;
    logic [15:0]        ctrl_w;
    logic [W-1:0]       cmp_buf_q [NCH];   // Software-visible buffer.
    logic [W-1:0]       cmp_act_q [NCH];   // Values driving matches.
    logic [W-1:0]       top_buf_q;
    logic [W-1:0]       top_act_q;
    logic               pending_q;
    logic               overflow_flag_q;
    logic [15:0]        port_q;
    logic               pwm_mode_enable;
    logic               lock;
    logic [W-1:0]       counter_value;
    logic               at_top;
    logic               wrap;
    logic               wr;
    logic               rd;
    logic               hit;
    logic               cnt_load;
    logic               ovf_set;
    logic               ovf_clr;
    logic               commit;
    logic [31:0]        rdata_d;

    assign pwm_mode_enable = ctrl_q[tcp_pkg::CTRL_PWM_EN] && !ctrl_q[tcp_pkg::CTRL_SLOPE];  // RULE4 RULE11
    assign lock            = ctrl_q[tcp_pkg::CTRL_LOCK];
    // Mode codes run past bit 7, so channel D takes its two bits from the high control byte.
    assign ctrl_w          = {ctrl_hi_q, ctrl_q};
    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign hit = (paddr == tcp_pkg::ADDR_CTRL) || (paddr == tcp_pkg::ADDR_CMP_A) ||
                 (paddr == tcp_pkg::ADDR_CMP_B) || (paddr == tcp_pkg::ADDR_CMP_D) ||
                 (paddr == tcp_pkg::ADDR_TOP)   || (paddr == tcp_pkg::ADDR_COUNT) ||
                 (paddr == tcp_pkg::ADDR_STATUS) || (paddr == tcp_pkg::ADDR_PORT);
    assign cnt_load = wr && (paddr == tcp_pkg::ADDR_COUNT);

    // Commit buffered values at cycle end unless locked; the pending flag stretches
    // a lock release until the running cycle finishes.
    assign commit = wrap && !lock && pending_q;                                  // RULE1 RULE2 RULE3

    // Overflow: in normal mode on the cycle the counter becomes zero, in fast PWM at TOP.
    assign ovf_set = pwm_mode_enable ? at_top : wrap;                            // RULE8 RULE14
    assign ovf_clr = wr && (paddr == tcp_pkg::ADDR_STATUS) && pwdata[tcp_pkg::STAT_OVF];

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    tcp_count #(.W(W)) u_count (
        .clock         (clock),
        .arst_n        (arst_n),
        .top_value     (top_act_q),
        .load          (cnt_load),
        .load_value    (pwdata[W-1:0]),
        .counter_value (counter_value),
        .at_top        (at_top),
        .wrap          (wrap)
    );

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            tcp_wave u_wave (
                .clock               (clock),
                .arst_n              (arst_n),
                .pwm_mode_enable     (pwm_mode_enable),
                .compare_output_mode (ctrl_w[tcp_pkg::CTRL_COM_LSB+2*g +: 2]),
                .match               (counter_value == cmp_act_q[g]),
                .at_bottom           (wrap),   // Edge on which the counter turns to BOTTOM.
                .port_true           (port_q[2*g]),
                .port_comp           (port_q[2*g+1]),
                .dir_true            (port_q[tcp_pkg::PORT_DIR_LSB+2*g]),
                .dir_comp            (port_q[tcp_pkg::PORT_DIR_LSB+2*g+1]),
                .pin_true_o          (pin_true_o[g]),
                .pin_comp_o          (pin_comp_o[g]),
                .pin_true_oe         (pin_true_oe[g]),
                .pin_comp_oe         (pin_comp_oe[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Register writes and shadow loads
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q          <= 8'h00;
            ctrl_hi_q       <= 8'h00;
            top_buf_q       <= tcp_pkg::TOP_RESET;
            top_act_q       <= tcp_pkg::TOP_RESET;
            pending_q       <= 1'b0;
            overflow_flag_q <= 1'b0;
            port_q          <= 16'h0000;
            for (int i = 0; i < NCH; i++) begin
                cmp_buf_q[i] <= '0;
                cmp_act_q[i] <= '0;
            end
        end else begin
            if (wr && paddr == tcp_pkg::ADDR_CTRL) begin
                ctrl_q    <= pwdata[7:0];
                ctrl_hi_q <= pwdata[15:8];
            end
            if (wr && paddr == tcp_pkg::ADDR_PORT) begin
                port_q <= pwdata[15:0];
            end
            if (wr && paddr == tcp_pkg::ADDR_TOP) begin
                top_buf_q <= pwdata[W-1:0];
            end
            for (int i = 0; i < NCH; i++) begin
                if (wr && paddr == tcp_pkg::ADDR_CMP_A + 12'(4 * i)) begin
                    cmp_buf_q[i] <= pwdata[W-1:0];                               // RULE20 RULE2
                end
                if (commit) begin
                    cmp_act_q[i] <= cmp_buf_q[i];                                // RULE3 RULE20
                end
            end
            if (commit) begin
                top_act_q <= top_buf_q;                                          // RULE1
            end
            // A write landing on the commit edge stays pending for the next cycle.
            if (wr && (paddr == tcp_pkg::ADDR_TOP || paddr == tcp_pkg::ADDR_CMP_A ||
                       paddr == tcp_pkg::ADDR_CMP_B || paddr == tcp_pkg::ADDR_CMP_D)) begin
                pending_q <= 1'b1;
            end else if (commit) begin
                pending_q <= 1'b0;
            end
            // Set wins over a simultaneous software clear.
            if (ovf_set) begin
                overflow_flag_q <= 1'b1;                                         // RULE8 RULE14
            end else if (ovf_clr) begin
                overflow_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read mux and APB answer
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (paddr)
            tcp_pkg::ADDR_CTRL:   rdata_d = {16'h0000, ctrl_hi_q, ctrl_q};
            tcp_pkg::ADDR_CMP_A:  rdata_d = 32'(cmp_buf_q[0]);
            tcp_pkg::ADDR_CMP_B:  rdata_d = 32'(cmp_buf_q[1]);
            tcp_pkg::ADDR_CMP_D:  rdata_d = 32'(cmp_buf_q[2]);
            tcp_pkg::ADDR_TOP:    rdata_d = 32'(top_buf_q);
            tcp_pkg::ADDR_COUNT:  rdata_d = 32'(counter_value);
            tcp_pkg::ADDR_STATUS: rdata_d = {31'h0000_0000, overflow_flag_q};
            tcp_pkg::ADDR_PORT:   rdata_d = {16'h0000, port_q};
            default:              rdata_d = 32'h0000_0000;
        endcase
    end

    // Answer in the access cycle: pready rises one edge after setup.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (rd && !penable) begin
                prdata <= rdata_d;
            end
        end
    end
endmodule

// ===== tcp_chk_sva.sv
// Checker of the register bus handshake and pin direction behaviour of the timer.
`timescale 1ns/1ns
module tcp_chk (
    // Clock and reset
    input wire logic        clock,
    input wire logic        arst_n,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic [2:0]  pin_true_o,
    input wire logic [2:0]  pin_true_oe,
    input wire logic [2:0]  pin_comp_o,
    input wire logic [2:0]  pin_comp_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Steps of one transfer; the port write is seen in its access cycle.
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_port_wr;
        psel && penable && pwrite && paddr == tcp_pkg::ADDR_PORT;
    endsequence

    // The slave answers with no wait state and for one cycle only.
    a_ready_next: assert property (s_setup |=> pready) else $error("pready missing after setup");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
    a_map_ok: assert property (pready && paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped address refused");
    // Direction bits reach the pins within two edges, as the pins are registered.
    a_dir_off: assert property (s_port_wr ##0 pwdata[13:8] == 6'h00 |-> ##[1:2] (pin_true_oe == 3'h0 && pin_comp_oe == 3'h0))
        else $error("pin direction not released");
    a_dir_on: assert property (s_port_wr ##0 pwdata[13:8] == 6'h3f |-> ##[1:2] (pin_true_oe == 3'h7 && pin_comp_oe == 3'h7))
        else $error("pin direction not driven");
endmodule

bind tcp_top tcp_chk u_chk (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_true_o(pin_true_o), .pin_true_oe(pin_true_oe), .pin_comp_o(pin_comp_o), .pin_comp_oe(pin_comp_oe));

// ===== tcp_stage.sv
// Model of the power stage gate drivers behind the compare pins.
`timescale 1ns/1ns
module tcp_stage (
    // Pins from the timer
    input wire logic [2:0] pin_true_o,
    input wire logic [2:0] pin_true_oe,
    input wire logic [2:0] pin_comp_o,
    input wire logic [2:0] pin_comp_oe,
    // Gate levels
    output logic [2:0]     gate_true,
    output logic [2:0]     gate_comp
);
    // A released pin is pulled low by the driver, so an undriven stage stays off.
    assign gate_true = pin_true_o & pin_true_oe;
    assign gate_comp = pin_comp_o & pin_comp_oe;
endmodule

// ===== tcp_top_tb.sv
// Self-checking testbench of the compare/PWM timer.
`timescale 1ns/1ns
module tcp_top_tb;
    typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} tcp_note_t;
    logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, last;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [2:0]  pin_true_o, pin_true_oe, pin_comp_o, pin_comp_oe, gate_true, gate_comp;
    int          errors, num_checks, hi, edges, chi;
    int          nrm_hi[4] = '{0, 32, 0, 64};
    int          fst_hi[4] = '{0, 16, 16, 48};
    int          fst_ch[4] = '{0, 48, 0, 0};
    tcp_note_t   notes[$];
    tcp_note_t   cur;

    tcp_top #(.W(10)) DUT (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_true_o(pin_true_o), .pin_true_oe(pin_true_oe), .pin_comp_o(pin_comp_o), .pin_comp_oe(pin_comp_oe));
    tcp_stage u_stage (.pin_true_o(pin_true_o), .pin_true_oe(pin_true_oe), .pin_comp_o(pin_comp_o),
        .pin_comp_oe(pin_comp_oe), .gate_true(gate_true), .gate_comp(gate_comp));

    // Free-running 50 MHz clock.
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One transfer; an idle edge follows so psel is never re-raised in the step it falls.
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // Only the watchdog bounds this wait.
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task rd_note(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic er);
        notes.push_back('{e, m, er});
        apb(a, 1'b0, 32'h0);
    endtask

    // Counts high cycles, edges of the true gate and high cycles of the complement.
    task measure(input int n);
        hi = 0;
        chi = 0;
        edges = 0;
        last = gate_true[0];
        repeat (n) begin
            @(posedge clock);
            hi += int'(gate_true[0] === 1'b1);
            chi += int'(gate_comp[0] === 1'b1);
            edges += int'(gate_true[0] !== last);
            last = gate_true[0];
        end
    endtask

    task run_mode(input logic [31:0] ctrl);
        apb(tcp_pkg::ADDR_CTRL, 1'b1, ctrl);
        repeat (24) @(posedge clock);
        measure(64);
    endtask

    // Read results are compared against the oldest note.
    always @(posedge clock) begin
        if (arst_n && pready === 1'b1 && psel && penable && !pwrite && notes.size() > 0) begin
            cur = notes.pop_front();
            check("prdata", cur.exp & cur.mask, prdata & cur.mask);
            check("pslverr", {31'h0, cur.err}, {31'h0, pslverr});
        end
    end

    // Watchdog well beyond the few thousand cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        report_and_stop;
    end

    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        errors = 0;
        num_checks = 0;
        seed = 32'd54;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rd_note(tcp_pkg::ADDR_TOP, 32'h3ff, 32'h3ff, 1'b0);
        rd_note(tcp_pkg::ADDR_CTRL, 32'h0, 32'h3ff, 1'b0);
        rd_note(tcp_pkg::ADDR_CMP_A, 32'h0, 32'h3ff, 1'b0);
        rd_note(12'h020, 32'h0, 32'hffffffff, 1'b1);
        apb(tcp_pkg::ADDR_PORT, 1'b1, 32'h3f3f);
        repeat (4) @(posedge clock);
        check("gates", 32'h3f, {26'h0, gate_comp, gate_true});
        apb(tcp_pkg::ADDR_PORT, 1'b1, 32'h3f00);
        repeat (4) @(posedge clock);
        check("gates", 32'h0, {26'h0, gate_comp, gate_true});
        seed = xs(seed);
        apb(tcp_pkg::ADDR_COUNT, 1'b1, {23'h0, seed[8:0]});
        apb(tcp_pkg::ADDR_COUNT, 1'b0, 32'h0);
        check("count load", 32'h1, {31'h0, (rd[9:0] - {1'b0, seed[8:0]}) <= 10'd8});
        apb(tcp_pkg::ADDR_TOP, 1'b1, 32'h7);
        apb(tcp_pkg::ADDR_CMP_A, 1'b1, 32'h3);
        repeat (1100) @(posedge clock);
        apb(tcp_pkg::ADDR_COUNT, 1'b0, 32'h0);
        check("count top", 32'h1, {31'h0, rd[9:0] <= 10'h7});
        rd_note(tcp_pkg::ADDR_STATUS, 32'h1, 32'h1, 1'b0);
        for (int m = 1; m < 4; m++) begin
            run_mode(32'(m) << tcp_pkg::CTRL_COM_LSB);
            check("normal high", 32'(nrm_hi[m]), 32'(hi));
            check("normal comp", 32'h0, 32'(chi));
            if (m == 1) begin
                check("toggle edges", 32'd8, 32'(edges));
            end
        end
        // Channel D in set mode with compare zero must drive its true pin high.
        apb(tcp_pkg::ADDR_CTRL, 1'b1, 32'h300);
        repeat (16) @(posedge clock);
        check("chan d set", 32'h1, {31'h0, gate_true[2]});
        apb(tcp_pkg::ADDR_CMP_A, 1'b1, 32'h1);
        for (int m = 1; m < 4; m++) begin
            run_mode(32'h1 | (32'(m) << tcp_pkg::CTRL_COM_LSB));
            check("fast high", 32'(fst_hi[m]), 32'(hi));
            check("fast comp", 32'(fst_ch[m]), 32'(chi));
        end
        apb(tcp_pkg::ADDR_STATUS, 1'b1, 32'h1);
        repeat (16) @(posedge clock);
        rd_note(tcp_pkg::ADDR_STATUS, 32'h1, 32'h1, 1'b0);
        apb(tcp_pkg::ADDR_CTRL, 1'b1, 32'h25);
        apb(tcp_pkg::ADDR_CMP_A, 1'b1, 32'h5);
        run_mode(32'h25);
        check("locked high", 32'd16, 32'(hi));
        run_mode(32'h21);
        check("released high", 32'd48, 32'(hi));
        apb(tcp_pkg::ADDR_CMP_A, 1'b1, 32'h3);
        run_mode(32'h21);
        check("unlocked high", 32'd32, 32'(hi));
        report_and_stop;
    end
endmodule
